//--- verilog/sgs_defs.svh
`ifndef SGS_DEFS_SVH
`define SGS_DEFS_SVH
// register byte offsets
`define SGS_OFF_CTRL     8'h00
`define SGS_OFF_TMO      8'h04
`define SGS_OFF_ALT      8'h08
`define SGS_OFF_STATUS   8'h0C
`define SGS_OFF_IRQ_STAT 8'h10
`define SGS_OFF_IRQ_MASK 8'h14
// control field positions
`define SGS_CTRL_TOP_LSB 0
`define SGS_CTRL_TOP_MSB 2
`define SGS_CTRL_STEPACK 3
`define SGS_CTRL_WORDACK 4
`define SGS_CTRL_PWRSYNC 5
// reset values
`define SGS_CTRL_RST     6'h07
`define SGS_TMO_RST      16'h03E8
// interrupt status bits
`define SGS_IRQ_POS      0
`define SGS_IRQ_ALM_LSB  1
`define SGS_IRQ_GRP      5
// timing: system clock, prescaled tick, alarm duration
`define SGS_CLK_NS       100
`define SGS_TICK_US      1000
`define SGS_TICK_CYC     (`SGS_TICK_US * 1000 / `SGS_CLK_NS)
`define SGS_ALARM_S      3
`define SGS_ALARM_TICKS  (`SGS_ALARM_S * 1000000 / `SGS_TICK_US)
// answer codes
`define SGS_RESP_OKAY    2'h0
`define SGS_RESP_SLVERR  2'h2
`endif

//--- verilog/sgs_pkg.sv
`default_nettype none
package sgs_pkg;
  // who owns the current pre-selection
  typedef enum logic [1:0] {SEQ_BOOT, SEQ_IDLE, SEQ_STEP, SEQ_WORD} sgs_seq_t;

  // sampled control inputs, one bundle
  typedef struct packed {
    logic       blk;
    logic [4:0] req;
    logic       step;
    logic       sack;
    logic [2:0] word;
    logic       wack;
  } sgs_in_t;

  // whole state of the selector
  typedef struct packed {
    sgs_in_t          s1, s2, pv;
    logic [15:0]      presc;
    logic             tick;
    logic [2:0]       grp;
    sgs_seq_t         seq;
    logic [1:0]       boot;
    logic [2:0]       pos, pre;
    logic [15:0]      tmr;
    logic [3:0]       alm;
    logic [3:0][15:0] acnt;
    logic             nvw;
    logic [5:0]       ctrl;
    logic [15:0]      tmo, alt;
    logic [5:0]       ist, imsk;
    logic             irq;
    logic             awr, wr, bv, arr, rv, aw_h, w_h;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata, wd;
    logic [7:0]       awa;
    logic [3:0]       ws;
  } sgs_state_t;
endpackage : sgs_pkg
`default_nettype wire

//--- verilog/sgs_selector.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sgs_defs.svh"

// Contract
// RL1 - group change block asserted freezes the active group.
// RL2 - up to six groups; highest-numbered requested group becomes active.
// RL3 - group 1 has no request; it is active when no other is.
// RL4 - each advance pulse moves the pre-selection up one step.
// RL5 - advancing from the top position wraps to position 1.
// RL6 - the three-bit word pre-selects the position it encodes.
// RL7 - pre-selection kept apart; applied after time-out or confirmation per mode.
// RL8 - word acted on only between 1 and top; otherwise no change.
// RL9 - out-of-range word raises the range alarm for 3 seconds.
// RL10 - applied position goes to non-volatile storage.
// RL11 - power-up restores stored position or syncs to the word, by option.
// RL12 - one time-out; time-out mode applies after that much input inactivity.
// RL13 - word 000 is rest, no action; 001 to 111 mean positions 1-7.
// RL14 - advance and word inputs lock each other out during a sequence.
// RL15 - acknowledge mode applies on the confirmation rising edge.
// RL16 - no confirmation within time-out discards change, alarm for 3 seconds.
// RL17 - rising edges found against the previous-cycle registered sample.
// RL18 - time-out and alarms count prescaled ticks, terminal counts from configuration.
module sgs_selector
  import sgs_pkg::*;
#(
  parameter int TICK_CYC = `SGS_TICK_CYC
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        group_change_block,
  input  wire logic [4:0]  group_act_req,
  input  wire logic        step_in,
  input  wire logic        step_ack,
  input  wire logic [2:0]  position_word,
  input  wire logic        word_ack,
  input  wire logic [2:0]  nvm_pos_in,
  output logic [2:0]       nvm_pos,
  output logic             nvm_wr,
  output logic [2:0]       active_group,
  output logic [2:0]       sel_position,
  output logic             range_alarm,
  output logic             step_alarm,
  output logic             word_alarm,
  output logic             pwr_alarm,
  output logic             irq
);

  sgs_state_t q, n;
  logic       st_r, ak_r, wk_r, wchg;
  logic [2:0] top;

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////
  // edges against last cycle's synchronised sample
  assign st_r = q.s2.step & ~q.pv.step;  // RL17
  assign ak_r = q.s2.sack & ~q.pv.sack;  // RL17
  assign wk_r = q.s2.wack & ~q.pv.wack;  // RL17
  assign wchg = q.s2.word != q.pv.word;
  assign top  = q.ctrl[`SGS_CTRL_TOP_MSB:`SGS_CTRL_TOP_LSB];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic [5:0] ev;
    logic [2:0] w;
    logic [2:0] base;
    logic       mode;
    logic       ackr;
    logic       clr;
    ev   = '0;
    w    = '0;
    base = '0;
    mode = 1'b0;
    ackr = 1'b0;
    clr  = 1'b0;
    n    = q;
    // pins pass two flops; the first stage feeds only the second
    n.s1  = {group_change_block, group_act_req, step_in, step_ack, position_word, word_ack};
    n.s2  = q.s1;
    n.pv  = q.s2;
    n.nvw = 1'b0;
    // prescaler makes the one-cycle timing tick
    n.tick = 1'b0;
    if (q.presc >= 16'(TICK_CYC - 1))
    begin
      n.presc = '0;
      n.tick  = 1'b1;  // RL18
    end
    else
      n.presc = q.presc + 16'h0001;
    // group arbitration; later loop passes win, so highest number rules
    if (!q.s2.blk)  // RL1
    begin
      n.grp = 3'h1;  // RL3
      for (int i = 0; i < 5; i++)
        if (q.s2.req[i]) n.grp = 3'(i + 2);  // RL2
    end
    // alarm timers run down on ticks
    for (int i = 0; i < 4; i++)
      if (q.tick && q.acnt[i] != 16'h0000)
      begin
        n.acnt[i] = q.acnt[i] - 16'h0001;
        if (q.acnt[i] == 16'h0001) n.alm[i] = 1'b0;  // RL18
      end
    // selector sequencing
    case (q.seq)
      SEQ_BOOT:
      begin
        // wait until the synchroniser holds a real sample
        if (q.boot == 2'h2)
        begin
          w     = q.ctrl[`SGS_CTRL_PWRSYNC] ? q.s2.word : nvm_pos_in;  // RL11
          n.seq = SEQ_IDLE;
          if (w != 3'h0 && w <= top)
            n.pos = w;
          else
          begin
            n.pos     = 3'h0;
            n.alm[3]  = 1'b1;
            n.acnt[3] = q.alt;
            ev[4]     = 1'b1;
          end
          n.pre = n.pos;
        end
        else
          n.boot = q.boot + 2'h1;
      end
      SEQ_IDLE, SEQ_STEP, SEQ_WORD:
      begin
        if (st_r && q.seq != SEQ_WORD)  // RL14
        begin
          base  = (q.seq == SEQ_STEP) ? q.pre : q.pos;
          n.pre = (base >= top) ? 3'h1 : base + 3'h1;  // RL4 RL5
          n.tmr = q.tmo;  // RL12
          n.seq = SEQ_STEP;
        end
        else if (wchg && q.seq != SEQ_STEP && q.s2.word != 3'h0)  // RL13 RL14
        begin
          if (q.s2.word <= top)  // RL8
          begin
            n.pre = q.s2.word;  // RL6
            n.tmr = q.tmo;
            n.seq = SEQ_WORD;
          end
          else
          begin
            n.alm[0]  = 1'b1;  // RL9
            n.acnt[0] = q.alt;
            ev[1]     = 1'b1;
          end
        end
        else if (q.seq != SEQ_IDLE)
        begin
          mode = (q.seq == SEQ_STEP) ? q.ctrl[`SGS_CTRL_STEPACK] : q.ctrl[`SGS_CTRL_WORDACK];
          ackr = (q.seq == SEQ_STEP) ? ak_r : wk_r;
          if (mode && ackr)
          begin
            n.pos = q.pre;  // RL15 RL7
            n.nvw = 1'b1;   // RL10
            n.seq = SEQ_IDLE;
            ev[0] = 1'b1;
          end
          else if (q.tick && q.tmr <= 16'h0001)
          begin
            n.seq = SEQ_IDLE;
            if (mode)
            begin
              // confirmation missed: drop the change
              n.pre = q.pos;  // RL16
              if (q.seq == SEQ_STEP)
              begin
                n.alm[1]  = 1'b1;
                n.acnt[1] = q.alt;
                ev[2]     = 1'b1;
              end
              else
              begin
                n.alm[2]  = 1'b1;
                n.acnt[2] = q.alt;
                ev[3]     = 1'b1;
              end
            end
            else
            begin
              n.pos = q.pre;  // RL12 RL7
              n.nvw = 1'b1;   // RL10
              ev[0] = 1'b1;
            end
          end
          else if (q.tick)
            n.tmr = q.tmr - 16'h0001;
        end
      end
      default: n.seq = SEQ_BOOT;
    endcase
    ev[`SGS_IRQ_GRP] = n.grp != q.grp;
    // bus write: address and data may come in either order
    if (q.awr && s_axi_awvalid)
    begin
      n.aw_h = 1'b1;
      n.awa  = s_axi_awaddr;
    end
    if (q.wr && s_axi_wvalid)
    begin
      n.w_h = 1'b1;
      n.wd  = s_axi_wdata;
      n.ws  = s_axi_wstrb;
    end
    if (q.aw_h && q.w_h && !q.bv)
    begin
      n.aw_h  = 1'b0;
      n.w_h   = 1'b0;
      n.bv    = 1'b1;
      n.bresp = `SGS_RESP_OKAY;
      case (q.awa)
        `SGS_OFF_CTRL:     n.ctrl = 6'(wmerge(32'(q.ctrl), q.wd, q.ws));
        `SGS_OFF_TMO:      n.tmo  = 16'(wmerge(32'(q.tmo), q.wd, q.ws));
        `SGS_OFF_ALT:      n.alt  = 16'(wmerge(32'(q.alt), q.wd, q.ws));
        `SGS_OFF_IRQ_MASK: n.imsk = 6'(wmerge(32'(q.imsk), q.wd, q.ws));
        `SGS_OFF_STATUS, `SGS_OFF_IRQ_STAT: n.bresp = `SGS_RESP_OKAY;
        default:           n.bresp = `SGS_RESP_SLVERR;
      endcase
    end
    if (q.bv && s_axi_bready) n.bv = 1'b0;
    // one write in flight; hold both channels while the answer waits
    n.awr = !n.aw_h && !n.bv;
    n.wr  = !n.w_h && !n.bv;
    // bus read
    if (q.arr && s_axi_arvalid)
    begin
      n.arr   = 1'b0;
      n.rv    = 1'b1;
      n.rresp = `SGS_RESP_OKAY;
      case (s_axi_araddr)
        `SGS_OFF_CTRL:     n.rdata = 32'(q.ctrl);
        `SGS_OFF_TMO:      n.rdata = 32'(q.tmo);
        `SGS_OFF_ALT:      n.rdata = 32'(q.alt);
        `SGS_OFF_STATUS:   n.rdata = 32'({q.alm, q.seq == SEQ_STEP || q.seq == SEQ_WORD, q.grp, q.pre, q.pos});
        `SGS_OFF_IRQ_STAT:
        begin
          n.rdata = 32'(q.ist);
          clr     = 1'b1;
        end
        `SGS_OFF_IRQ_MASK: n.rdata = 32'(q.imsk);
        default:
        begin
          n.rdata = 32'h0000_0000;
          n.rresp = `SGS_RESP_SLVERR;
        end
      endcase
    end
    if (q.rv && s_axi_rready)
    begin
      n.rv  = 1'b0;
      n.arr = 1'b1;
    end
    // sticky status: an event in the clearing cycle survives
    n.ist = (clr ? 6'h00 : q.ist) | ev;
    n.irq = |(n.ist & n.imsk);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q      <= '0;
      q.seq  <= SEQ_BOOT;
      q.grp  <= 3'h1;
      q.ctrl <= `SGS_CTRL_RST;
      q.tmo  <= `SGS_TMO_RST;
      q.alt  <= 16'(`SGS_ALARM_TICKS);
      q.awr  <= 1'b1;
      q.wr   <= 1'b1;
      q.arr  <= 1'b1;
    end
    else
      q <= n;
  end

  // every output straight from the state register
  assign s_axi_awready = q.awr;
  assign s_axi_wready  = q.wr;
  assign s_axi_bvalid  = q.bv;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arr;
  assign s_axi_rvalid  = q.rv;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign nvm_pos       = q.pos;
  assign nvm_wr        = q.nvw;
  assign active_group  = q.grp;
  assign sel_position  = q.pos;
  assign range_alarm   = q.alm[0];
  assign step_alarm    = q.alm[1];
  assign word_alarm    = q.alm[2];
  assign pwr_alarm     = q.alm[3];
  assign irq           = q.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_step_ack;
    q.seq == SEQ_STEP && q.ctrl[`SGS_CTRL_STEPACK] && ak_r && !st_r;
  endsequence
  sequence s_step_exp;
    q.seq == SEQ_STEP && !st_r && !(q.ctrl[`SGS_CTRL_STEPACK] && ak_r) && q.tick && q.tmr <= 16'h0001;
  endsequence

  grp_hold_a: assert property (q.s2.blk |=> $stable(q.grp)) else $error("group moved while blocked"); // RL1
  grp_prio_a: assert property (!q.s2.blk && q.s2.req[4] |=> q.grp == 3'h6) else $error("group 6 lost"); // RL2
  grp_dflt_a: assert property (!q.s2.blk && q.s2.req == 5'h00 |=> q.grp == 3'h1) else $error("no default"); // RL3
  step_inc_a: assert property (q.seq == SEQ_STEP && st_r && q.pre < top |=> q.pre == $past(q.pre) + 3'h1)
    else $error("step not by one"); // RL4
  step_wrap_a: assert property (q.seq == SEQ_STEP && st_r && q.pre >= top |=> q.pre == 3'h1)
    else $error("no wrap to 1"); // RL5
  word_pre_a: assert property (q.seq == SEQ_IDLE && !st_r && wchg && q.s2.word != 3'h0 && q.s2.word <= top
    |=> q.pre == $past(q.s2.word) && q.seq == SEQ_WORD) else $error("word not preselected"); // RL6
  word_range_a: assert property (q.seq == SEQ_IDLE && !st_r && wchg && q.s2.word > top
    |=> q.alm[0] && $stable(q.pos) && q.seq == SEQ_IDLE) else $error("range not caught"); // RL8
  lock_out_a: assert property (q.seq == SEQ_STEP && !st_r |=> q.pre == $past(q.pre) || q.seq == SEQ_IDLE)
    else $error("word broke step"); // RL14
  ack_apply_a: assert property (s_step_ack |=> q.pos == $past(q.pre) && q.nvw) else $error("ack not applied"); // RL15
  tmo_apply_a: assert property (s_step_exp ##0 !q.ctrl[`SGS_CTRL_STEPACK] |=> q.pos == $past(q.pre) && q.nvw)
    else $error("timeout not applied"); // RL12
  ack_miss_a: assert property (s_step_exp ##0 q.ctrl[`SGS_CTRL_STEPACK] |=> q.alm[1] && $stable(q.pos))
    else $error("missed ack not alarmed"); // RL16
  tick_gap_a: assert property (q.tick |=> !q.tick [*2]) else $error("tick too dense"); // RL18

endmodule : sgs_selector
`default_nettype wire

//--- verif/sgs_operand_model.sv
`timescale 1ns/10ps
`default_nettype none
// pushbutton and operand side: each press request becomes a 4-cycle pulse
module sgs_operand_model (
  input  wire logic       aclk,
  input  wire logic [2:0] press,
  output logic            step_in,
  output logic            step_ack,
  output logic            word_ack
);
  int cnt_ff [3];

  // stretched so the two-flop sync always sees it; callers leave gaps
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 3; i++)
      cnt_ff[i] <= press[i] ? 4 : (cnt_ff[i] > 0 ? cnt_ff[i] - 1 : 0);
  end

  // buttons rest low between presses
  assign step_in  = cnt_ff[0] > 0;
  assign step_ack = cnt_ff[1] > 0;
  assign word_ack = cnt_ff[2] > 0;
endmodule : sgs_operand_model
`default_nettype wire

//--- verif/test_setting_group_selector.sv
`timescale 1ns/10ps
`default_nettype none
`include "sgs_defs.svh"
module test_setting_group_selector;
  logic        aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wr, arr;
  logic        blk, sin, sack, wack, nwr, irq, ral, sal, wal, pal;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  bresp, rresp;
  logic [4:0]  req;
  logic [2:0]  pw, npi, npo, grp, pos, press;
  logic [3:0]  seen;
  int          n_errors, comparisons, n_wr, m_wr, m_pos, m_top, m_grp, cyc;
  int          wl [4] = '{4, 0, 6, 2};

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // short tick so time-outs take tens of cycles, not thousands
  sgs_selector #(.TICK_CYC(4)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .group_change_block(blk), .group_act_req(req), .step_in(sin), .step_ack(sack),
    .position_word(pw), .word_ack(wack), .nvm_pos_in(npi), .nvm_pos(npo), .nvm_wr(nwr),
    .active_group(grp), .sel_position(pos), .range_alarm(ral), .step_alarm(sal),
    .word_alarm(wal), .pwr_alarm(pal), .irq(irq));

  sgs_operand_model pm (.aclk(aclk), .press(press), .step_in(sin), .step_ack(sack), .word_ack(wack));

  ////////////////////////////////////////////////////////////////////////
  // store-write count, sticky alarm record, hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (nwr === 1'b1) n_wr++;
    seen = seen | {pal, wal, sal, ral};
    if (cyc > 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // write: address and data offered together, each dropped once taken
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `SGS_RESP_OKAY);
    int t;
    t = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && t < 50);
    br <= 1'b0;
    // no answer within the wait counts as a mismatch
    if (t >= 50) n_errors++;
    chk("bresp", bresp, er);
  endtask : axw

  // read: m masks bits whose value is not predicted
  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `SGS_RESP_OKAY,
           input logic [31:0] m = 32'hFFFFFFFF);
    int t;
    t = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && t < 50);
    rr <= 1'b0;
    if (t >= 50) n_errors++;
    chk("rdata", rd & m, e);
    chk("rresp", rresp, er);
  endtask : axr

  task push(input int b);
    @(posedge aclk);
    press <= 3'b001 << b;
    @(posedge aclk);
    press <= 3'b000;
    repeat (10) @(posedge aclk);
  endtask : push

  task do_reset(input logic [2:0] p);
    npi <= p;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    m_wr = n_wr;
    seen = 4'h0;
  endtask : do_reset

  // model position against output, store copy and store-write count
  task expect_pos(input string nm);
    chk(nm, pos, m_pos);
    chk("stored position", npo, m_pos);
    chk("store writes", n_wr, m_wr);
    $display("test %s done", nm);
  endtask : expect_pos

  function automatic int hi_grp(input logic [4:0] r);
    for (int i = 4; i >= 0; i--)
      if (r[i]) return i + 2;
    return 1;
  endfunction : hi_grp

  task wrap_up;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {awv, wv, br, arv, rr, blk, aresetn} = '0;
    {awa, ara, wd, req, pw, press, seen} = '0;
    npi = 3'h3;
    void'($urandom(32'hF37B2B33));
    do_reset(3'h3);
    m_pos = 3;
    chk("restored position", pos, 3'h3);
    chk("default group", grp, 3'h1);
    axr(`SGS_OFF_CTRL, 32'h7);
    axr(`SGS_OFF_TMO, 32'h3E8);
    axr(`SGS_OFF_ALT, 32'hBB8);
    axr(`SGS_OFF_IRQ_MASK, 32'h0);
    axw(8'h18, 32'h1, `SGS_RESP_SLVERR);
    axr(8'h18, 32'h0, `SGS_RESP_SLVERR);
    // short time-out and alarm, top position 5, both time-out modes
    axw(`SGS_OFF_TMO, 32'h5);
    axw(`SGS_OFF_ALT, 32'h3);
    axw(`SGS_OFF_CTRL, 32'h5);
    m_top = 5;
    axr(`SGS_OFF_IRQ_STAT, 32'h0, `SGS_RESP_OKAY, 32'h0);
    axw(`SGS_OFF_IRQ_MASK, 32'h1);
    $display("test registers done");
    // random requests, then frozen, then released
    for (int i = 0; i < 10; i++)
    begin
      req <= 5'($urandom);
      repeat (6) @(posedge aclk);
      chk("group", grp, hi_grp(req));
    end
    m_grp = hi_grp(req);
    blk <= 1'b1;
    repeat (6) @(posedge aclk);
    req <= ~req;
    repeat (6) @(posedge aclk);
    chk("blocked group", grp, m_grp);
    blk <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("released group", grp, hi_grp(req));
    $display("test groups done");
    // words: in range, rest, above top, in range
    foreach (wl[i])
    begin
      seen = 4'h0;
      pw <= 3'(wl[i]);
      repeat (60) @(posedge aclk);
      if (wl[i] >= 1 && wl[i] <= m_top)
      begin
        m_pos = wl[i];
        m_wr++;
      end
      chk("range alarm", seen[0], wl[i] > m_top);
      chk("range alarm over", ral, 1'b0);
      expect_pos("word");
      if (i == 0)
      begin
        chk("irq", irq, 1'b1);
        axr(`SGS_OFF_IRQ_STAT, 32'h1, `SGS_RESP_OKAY, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq cleared", irq, 1'b0);
      end
    end
    // four advances from 2 with top 5 wrap to 1; word change meanwhile ignored
    for (int i = 0; i < 4; i++)
    begin
      push(0);
      m_pos = (m_pos >= m_top) ? 1 : m_pos + 1;
    end
    pw <= 3'h4;
    m_wr++;
    repeat (60) @(posedge aclk);
    expect_pos("step wrap");
    // acknowledge mode for the advance input, confirmed then missed
    axw(`SGS_OFF_CTRL, 32'hD);
    push(0);
    push(1);
    m_pos = m_pos + 1;
    m_wr++;
    repeat (5) @(posedge aclk);
    expect_pos("step ack");
    seen = 4'h0;
    push(0);
    repeat (60) @(posedge aclk);
    chk("step alarm", seen[1], 1'b1);
    expect_pos("step missed");
    // acknowledge mode for the word, confirmed then missed
    axw(`SGS_OFF_CTRL, 32'h15);
    pw <= 3'h3;
    repeat (10) @(posedge aclk);
    push(2);
    m_pos = 3;
    m_wr++;
    repeat (5) @(posedge aclk);
    expect_pos("word ack");
    seen = 4'h0;
    pw <= 3'h5;
    repeat (60) @(posedge aclk);
    chk("word alarm", seen[2], 1'b1);
    expect_pos("word missed");
    // status word: alarms over, idle, group, preselection and position agree
    axr(`SGS_OFF_STATUS, (hi_grp(req) << 6) | (3 << 3) | 3);
    // power-up with an empty store gives no position and an alarm
    do_reset(3'h0);
    chk("empty restore", pos, 3'h0);
    chk("power alarm", pal, 1'b1);
    $display("test power-up done");
    wrap_up();
  end
endmodule : test_setting_group_selector
`default_nettype wire
